// File: common/adcsq_defines.svh
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

// register word addresses (byte address = index * 4)
`define ADCSQ_IDX_INSEL     3'h0
`define ADCSQ_IDX_CTRL      3'h1
`define ADCSQ_IDX_RESLO     3'h2
`define ADCSQ_IDX_RESHI     3'h3
`define ADCSQ_IDX_TRIGSEL   3'h4
`define ADCSQ_IDX_SYSCTL    3'h5

// input select fields
`define ADCSQ_REF_MSB       7
`define ADCSQ_REF_LSB       6
`define ADCSQ_LADJ_BIT      5
`define ADCSQ_MUX_MSB       4
`define ADCSQ_MUX_LSB       0

// control/status fields
`define ADCSQ_EN_BIT        7
`define ADCSQ_START_BIT     6
`define ADCSQ_ATE_BIT       5
`define ADCSQ_DONE_BIT      4
`define ADCSQ_DIE_BIT       3
`define ADCSQ_PS_MSB        2
`define ADCSQ_PS_LSB        0

// trigger select field
`define ADCSQ_TS_MSB        7
`define ADCSQ_TS_LSB        5

// system control bits: global interrupt enable, vector acknowledge
`define ADCSQ_GIE_BIT       0
`define ADCSQ_VACK_BIT      1

`define ADCSQ_RESET_BYTE    8'h00
`define ADCSQ_FIRST_CYCLES  5'h19
`define ADCSQ_NORM_CYCLES   5'h0d
`define ADCSQ_TS_FREE       3'h0

`endif

// File: common/adcsq_pkg.sv
package adcsq_pkg;
    typedef enum logic [1:0] {
        ADCSQ_REF_EXT_PIN,
        ADCSQ_REF_ANALOG_SUPPLY,
        ADCSQ_REF_RESERVED,
        ADCSQ_REF_INT_2V56
    } adcsq_ref_e;

    typedef enum logic [1:0] {
        ADCSQ_GAIN_1X,
        ADCSQ_GAIN_10X,
        ADCSQ_GAIN_200X,
        ADCSQ_GAIN_NONE
    } adcsq_gain_e;

    typedef enum {
        ADCSQ_IDLE,
        ADCSQ_CONV
    } adcsq_state_e;
endpackage : adcsq_pkg

// File: core/adcsq_prescaler.sv
`timescale 1ns/1ps
`include "adcsq_defines.svh"

module adcsq_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] div_sel_i,
    output logic            tick_o
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;
    logic [6:0] limit;

    always_comb begin
        case (div_sel_i)
            3'h0, 3'h1: limit = 7'h01;
            default:    limit = 7'((8'h01 << div_sel_i) - 8'h01);
        endcase
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run_i) begin
            cnt_next = 7'h00;
        end else if (cnt_reg >= limit) begin
            cnt_next  = 7'h00;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule : adcsq_prescaler

// File: core/adcsq_control.sv
// Summary of operation
// - reference field picks external, supply or 2.56V
// - reference and input changes wait for the next conversion start
// - bit 5 set left-adjusts the result
// - left-adjust change shows at once
// - codes 0-7 single inputs, bandgap, ground
// - 10x and 200x differential pair codes
// - 1x pairs, negative input 1 or 2
// - enable on; disable aborts running conversion
// - start write begins single or first conversion
// - first conversion 25 cycles, then 13
// - start reads one while busy; zero ignored
// - auto-trigger starts on selected source rising edge
// - done sets at conversion end, also when a low byte read holds the result
// - done cleared by vector or writing one
// - interrupt when done, enable and global set
// - prescaler divides clock by 2 to 128
// - trigger field selects free running or sources
// - low byte read locks result until high read
// - differential results are two's complement
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "adcsq_defines.svh"

module adcsq_control #(
    parameter int RES_W = 10
) (
    input  wire logic             CLK_I,
    input  wire logic             RESET_N_I,
    input  wire logic             CYC_I,
    input  wire logic             STB_I,
    input  wire logic             WE_I,
    input  wire logic [4:0]       ADR_I,
    input  wire logic [3:0]       SEL_I,
    input  wire logic [31:0]      DAT_I,
    output logic      [31:0]      DAT_O,
    output logic                  ACK_O,
    input  wire logic [6:0]       TRIG_SOURCES_I,
    input  wire logic [RES_W-1:0] CONV_CODE_I,
    output logic                  CONV_SAMPLE_O,
    output logic                  CONV_POWER_O,
    output logic      [1:0]       REFERENCE_SELECT_O,
    output logic      [3:0]       POS_INPUT_O,
    output logic      [1:0]       NEG_INPUT_O,
    output logic      [1:0]       GAIN_O,
    output logic                  DIFFERENTIAL_O,
    output logic                  BANDGAP_SEL_O,
    output logic                  GROUND_SEL_O,
    output logic                  DONE_IRQ_O
);
    logic rst_s1_reg;
    logic rst_n;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // bus decode
    logic       bus_req;
    logic       wr_en;
    logic       rd_en;
    logic [2:0] idx;
    assign bus_req = CYC_I && STB_I && !ACK_O;
    assign wr_en   = bus_req && WE_I && SEL_I[0];
    assign rd_en   = bus_req && !WE_I;
    assign idx     = ADR_I[4:2];

    // channel decode, pure function of the latched select code
    function automatic logic [10:0] mux_decode(input logic [4:0] code);
        logic [3:0] pos;
        logic [1:0] neg;
        logic [1:0] gain;
        logic       diff;
        logic       bg;
        logic       gnd;
        pos  = 4'h0;
        neg  = 2'h0;
        gain = adcsq_pkg::ADCSQ_GAIN_NONE;
        diff = 1'b0;
        bg   = 1'b0;
        gnd  = 1'b0;
        if (code[4:3] == 2'h0) begin
            pos = {1'b0, code[2:0]};
        end else if (code[4:3] == 2'h1) begin
            diff = 1'b1;
            pos  = {2'h0, code[2], code[0]};
            neg  = {code[2], 1'b0};
            gain = code[1] ? adcsq_pkg::ADCSQ_GAIN_200X : adcsq_pkg::ADCSQ_GAIN_10X;
        end else if (code == 5'h1e) begin
            bg = 1'b1;
        end else if (code == 5'h1f) begin
            gnd = 1'b1;
        end else begin
            diff = 1'b1;
            pos  = {1'b0, code[2:0]};
            neg  = code[3] ? 2'h2 : 2'h1;
            gain = adcsq_pkg::ADCSQ_GAIN_1X;
        end
        return {pos, neg, gain, diff, bg, gnd};
    endfunction : mux_decode

    // register state
    logic [7:0]       insel_reg,   insel_next;
    logic [7:0]       active_reg,  active_next;
    logic             en_reg,      en_next;
    logic             ate_reg,     ate_next;
    logic             done_reg,    done_next;
    logic             die_reg,     die_next;
    logic [2:0]       ps_reg,      ps_next;
    logic [2:0]       ts_reg,      ts_next;
    logic             gie_reg,     gie_next;
    logic             first_reg,   first_next;
    logic [RES_W-1:0] result_reg,  result_next;
    logic             locked_reg,  locked_next;
    logic [4:0]       cycles_reg,  cycles_next;
    logic             trig_d_reg,  trig_d_next;
    adcsq_pkg::adcsq_state_e state_reg, state_next;
    logic [31:0]      dat_next;
    logic             irq_next;
    logic             sample_next;
    logic             tick;
    logic             trig_now;
    logic             start_req;
    logic [15:0]      adj;

    adcsq_prescaler u_prescaler (
        .clk_i     (CLK_I),
        .rst_n_i   (rst_n),
        .run_i     (en_reg),
        .div_sel_i (ps_reg),
        .tick_o    (tick)
    );

    // free running restarts at completion; switching into it must not fire an edge
    assign trig_now = (ts_reg == `ADCSQ_TS_FREE) ? 1'b0 : TRIG_SOURCES_I[ts_reg - 3'h1];

    // presentation follows the live left-adjust bit
    assign adj = insel_reg[`ADCSQ_LADJ_BIT] ? {result_reg, 6'h00}
                                              : {6'h00, result_reg};

    always_comb begin
        insel_next  = insel_reg;
        active_next = active_reg;
        en_next     = en_reg;
        ate_next    = ate_reg;
        done_next   = done_reg;
        die_next    = die_reg;
        ps_next     = ps_reg;
        ts_next     = ts_reg;
        gie_next    = gie_reg;
        first_next  = first_reg;
        result_next = result_reg;
        locked_next = locked_reg;
        cycles_next = cycles_reg;
        state_next  = state_reg;
        trig_d_next = trig_now;
        sample_next = 1'b0;
        dat_next    = 32'h0000_0000;
        start_req   = 1'b0;

        if (wr_en) begin
            case (idx)
                `ADCSQ_IDX_INSEL: insel_next = DAT_I[7:0];
                `ADCSQ_IDX_CTRL: begin
                    en_next  = DAT_I[`ADCSQ_EN_BIT];
                    ate_next = DAT_I[`ADCSQ_ATE_BIT];
                    die_next = DAT_I[`ADCSQ_DIE_BIT];
                    ps_next  = DAT_I[`ADCSQ_PS_MSB:`ADCSQ_PS_LSB];
                    if (DAT_I[`ADCSQ_DONE_BIT]) begin
                        done_next = 1'b0;
                    end
                    if (DAT_I[`ADCSQ_START_BIT] && DAT_I[`ADCSQ_EN_BIT]) begin
                        start_req = 1'b1;
                    end
                    if (DAT_I[`ADCSQ_EN_BIT] && !en_reg) begin
                        first_next = 1'b1;
                    end
                end
                `ADCSQ_IDX_TRIGSEL: ts_next = DAT_I[`ADCSQ_TS_MSB:`ADCSQ_TS_LSB];
                `ADCSQ_IDX_SYSCTL: begin
                    gie_next = DAT_I[`ADCSQ_GIE_BIT];
                    if (DAT_I[`ADCSQ_VACK_BIT]) begin
                        done_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // auto trigger on rising edge of selected source
        if (ate_reg && en_reg && trig_now && !trig_d_reg) begin
            start_req = 1'b1;
        end

        if (rd_en) begin
            case (idx)
                `ADCSQ_IDX_INSEL: dat_next = {24'h0, insel_reg};
                `ADCSQ_IDX_CTRL: dat_next = {24'h0, en_reg,
                    (state_reg == adcsq_pkg::ADCSQ_CONV),
                    ate_reg, done_reg, die_reg, ps_reg};
                `ADCSQ_IDX_RESLO: begin
                    dat_next    = {24'h0, adj[7:0]};
                    locked_next = 1'b1;
                end
                `ADCSQ_IDX_RESHI: begin
                    dat_next    = {24'h0, adj[15:8]};
                    locked_next = 1'b0;
                end
                `ADCSQ_IDX_TRIGSEL: dat_next = {24'h0, ts_reg, 5'h00};
                `ADCSQ_IDX_SYSCTL: dat_next = {31'h0, gie_reg};
                default: dat_next = 32'h0000_0000;
            endcase
        end

        case (state_reg)
            adcsq_pkg::ADCSQ_IDLE: begin
                if (start_req && (en_next)) begin
                    active_next = insel_next;
                    cycles_next = first_next ? `ADCSQ_FIRST_CYCLES
                                             : `ADCSQ_NORM_CYCLES;
                    first_next  = 1'b0;
                    sample_next = 1'b1;
                    state_next  = adcsq_pkg::ADCSQ_CONV;
                end
            end
            adcsq_pkg::ADCSQ_CONV: begin
                if (!en_next) begin
                    state_next = adcsq_pkg::ADCSQ_IDLE;
                end else if (tick) begin
                    if (cycles_reg == 5'h01) begin
                        if (!locked_next) begin
                            result_next = CONV_CODE_I;
                        end
                        done_next  = 1'b1;
                        state_next = adcsq_pkg::ADCSQ_IDLE;
                        // free running: next conversion follows directly
                        if (ate_reg && ts_reg == `ADCSQ_TS_FREE) begin
                            active_next = insel_next;
                            cycles_next = `ADCSQ_NORM_CYCLES;
                            sample_next = 1'b1;
                            state_next  = adcsq_pkg::ADCSQ_CONV;
                        end
                    end else begin
                        cycles_next = cycles_reg - 5'h01;
                    end
                end
            end
            default: state_next = adcsq_pkg::ADCSQ_IDLE;
        endcase

        irq_next = done_next && die_next && gie_next;
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            insel_reg     <= `ADCSQ_RESET_BYTE;
            active_reg    <= `ADCSQ_RESET_BYTE;
            en_reg        <= 1'b0;
            ate_reg       <= 1'b0;
            done_reg      <= 1'b0;
            die_reg       <= 1'b0;
            ps_reg        <= 3'h0;
            ts_reg        <= 3'h0;
            gie_reg       <= 1'b0;
            first_reg     <= 1'b0;
            result_reg    <= '0;
            locked_reg    <= 1'b0;
            cycles_reg    <= 5'h00;
            trig_d_reg    <= 1'b0;
            state_reg     <= adcsq_pkg::ADCSQ_IDLE;
            DAT_O         <= 32'h0000_0000;
            ACK_O         <= 1'b0;
            DONE_IRQ_O    <= 1'b0;
            CONV_SAMPLE_O <= 1'b0;
        end else begin
            insel_reg     <= insel_next;
            active_reg    <= active_next;
            en_reg        <= en_next;
            ate_reg       <= ate_next;
            done_reg      <= done_next;
            die_reg       <= die_next;
            ps_reg        <= ps_next;
            ts_reg        <= ts_next;
            gie_reg       <= gie_next;
            first_reg     <= first_next;
            result_reg    <= result_next;
            locked_reg    <= locked_next;
            cycles_reg    <= cycles_next;
            trig_d_reg    <= trig_d_next;
            state_reg     <= state_next;
            DAT_O         <= dat_next;
            ACK_O         <= bus_req;
            DONE_IRQ_O    <= irq_next;
            CONV_SAMPLE_O <= sample_next;
        end
    end

    // analog selects come from the copy latched at conversion start
    logic [10:0] dec_next;
    assign dec_next = mux_decode(active_next[`ADCSQ_MUX_MSB:`ADCSQ_MUX_LSB]);

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CONV_POWER_O       <= 1'b0;
            REFERENCE_SELECT_O <= 2'h0;
            POS_INPUT_O        <= 4'h0;
            NEG_INPUT_O        <= 2'h0;
            GAIN_O             <= 2'h3;
            DIFFERENTIAL_O     <= 1'b0;
            BANDGAP_SEL_O      <= 1'b0;
            GROUND_SEL_O       <= 1'b0;
        end else begin
            CONV_POWER_O       <= en_next;
            REFERENCE_SELECT_O <= active_next[`ADCSQ_REF_MSB:`ADCSQ_REF_LSB];
            POS_INPUT_O        <= dec_next[10:7];
            NEG_INPUT_O        <= dec_next[6:5];
            GAIN_O             <= dec_next[4:3];
            DIFFERENTIAL_O     <= dec_next[2];
            BANDGAP_SEL_O      <= dec_next[1];
            GROUND_SEL_O       <= dec_next[0];
        end
    end
endmodule : adcsq_control

// File: verif/adcsq_sva.sv
`timescale 1ns/1ps
module adcsq_sva (
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        ACK_O,
    input wire logic [31:0] DAT_O,
    input wire logic        CONV_SAMPLE_O,
    input wire logic        CONV_POWER_O,
    input wire logic [3:0]  POS_INPUT_O,
    input wire logic [1:0]  GAIN_O,
    input wire logic        DIFFERENTIAL_O,
    input wire logic        BANDGAP_SEL_O,
    input wire logic        GROUND_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    AST_ACK_AFTER_REQ: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acknowledged one cycle later");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without a request");
    AST_DAT_UPPER: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_SAMPLE_POWER: assert property (CONV_SAMPLE_O |-> CONV_POWER_O)
        else $error("conversion started with converter off");
    AST_SAMPLE_GAP: assert property (CONV_SAMPLE_O |=> !CONV_SAMPLE_O [*8])
        else $error("conversions closer than the minimum length");
    AST_SEL_AT_START: assert property (
        $changed({POS_INPUT_O, GAIN_O, DIFFERENTIAL_O}) |-> CONV_SAMPLE_O || $past(CONV_SAMPLE_O))
        else $error("analog select changed outside a conversion start");
    AST_SINGLE_NO_GAIN: assert property (
        BANDGAP_SEL_O || GROUND_SEL_O |-> !DIFFERENTIAL_O && GAIN_O == 2'h3 && !(BANDGAP_SEL_O && GROUND_SEL_O))
        else $error("bandgap or ground select inconsistent");
    AST_DIFF_GAIN: assert property (DIFFERENTIAL_O |-> GAIN_O != 2'h3)
        else $error("differential pair without a gain");
endmodule : adcsq_sva

// File: verif/adcsq_conv_model.sv
`timescale 1ns/1ps
module adcsq_conv_model (
    input  wire logic       clk_i,
    input  wire logic       sample_i,
    input  wire logic [9:0] code_i,
    output logic      [9:0] code_o
);
    // code held from sample to the next sample, like the macro's output latch
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            code_o <= code_i;
        end
    end
endmodule : adcsq_conv_model

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, cyc, stb, we, ack, samp, pwr, diff, bg, gnd, irq;
    logic [4:0]  adr;
    logic [3:0]  sel, pos;
    logic [31:0] dat_w, dat_r;
    logic [6:0]  trig;
    logic [9:0]  code, next_code;
    logic [1:0]  refs, neg, gain;
    logic [7:0]  q;
    int          err_count, cmp_count;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    adcsq_control dut (.CLK_I(clk), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .TRIG_SOURCES_I(trig), .CONV_CODE_I(code), .CONV_SAMPLE_O(samp), .CONV_POWER_O(pwr),
        .REFERENCE_SELECT_O(refs), .POS_INPUT_O(pos), .NEG_INPUT_O(neg), .GAIN_O(gain),
        .DIFFERENTIAL_O(diff), .BANDGAP_SEL_O(bg), .GROUND_SEL_O(gnd), .DONE_IRQ_O(irq));
    adcsq_conv_model u_conv (.clk_i(clk), .sample_i(samp), .code_i(next_code), .code_o(code));

    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle; one idle cycle between requests comes from the leading edge wait
    task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wait_samp(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (samp !== 1'b1 && n < 5000);
    endtask : wait_samp

    task automatic count_samp(input int len, output int c);
        c = 0;
        repeat (len) begin
            @(posedge clk);
            if (samp === 1'b1) c++;
        end
    endtask : count_samp

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, 3'h1, 8'h00);
            n++;
        end while (q[6] !== 1'b0 && n < 2000);
        chk(32'(n < 2000), 32'h1);
    endtask : wait_idle

    task automatic s_regs();
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 3'(i), 8'h00);
            chk(32'(q), 32'h0);
        end
        wb(1'b1, 3'h6, 8'ha5);
        wb(1'b0, 3'h6, 8'h00);
        chk(32'(q), 32'h0);
        sel <= 4'he;
        wb(1'b1, 3'h0, 8'hff);
        sel <= 4'hf;
        wb(1'b0, 3'h0, 8'h00);
        chk(32'(q), 32'h0);
        wb(1'b1, 3'h4, 8'hff);
        wb(1'b0, 3'h4, 8'h00);
        chk(32'(q), 32'he0);
    endtask : s_regs

    task automatic s_mux();
        logic [4:0] c;
        wb(1'b1, 3'h1, 8'h80);
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            wb(1'b1, 3'h0, {c[1:0], 1'b0, c});
            wb(1'b1, 3'h1, 8'hc0);
            wait_idle();
            chk(32'(refs), 32'(c[1:0]));
            chk(32'({bg, gnd}), 32'({c == 5'd30, c == 5'd31}));
            chk(32'(diff), 32'(c >= 5'd8 && c < 5'd30));
            chk(32'(gain), (c < 5'd8 || c > 5'd29) ? 32'h3
                : c < 5'd16 ? 32'(c[1] + 1) : 32'h0);
            if (c < 5'd30) chk(32'(pos), c < 5'd8 || c > 5'd15
                ? 32'(c[2:0]) : 32'({c[2], c[0]}));
            if (c > 5'd7 && c < 5'd30) chk(32'(neg), c < 5'd16
                ? 32'(c[2] * 2) : 32'(c[3] + 1));
        end
    endtask : s_mux

    task automatic s_free();
        int a, b, d, n;
        for (int ps = 0; ps < 8; ps++) begin
            d = ps < 2 ? 2 : 1 << ps;
            wb(1'b1, 3'h1, 8'h00);
            wb(1'b1, 3'h4, 8'h00);
            wb(1'b1, 3'h1, 8'he0 | 8'(ps));
            wait_samp(a);
            wait_samp(b);
            chk(32'(a - b >= 11 * d && a - b <= 13 * d), 32'h1);
            chk(32'(b >= 13 * d && b <= 13 * d + 4), 32'h1);
        end
        wb(1'b1, 3'h1, 8'h00);
        count_samp(300, n);
        chk(32'(n), 32'h0);
        chk(32'(pwr), 32'h0);
    endtask : s_free

    task automatic s_trig();
        int c;
        for (int n = 1; n < 8; n++) begin
            wb(1'b1, 3'h1, 8'h00);
            wb(1'b1, 3'h4, 8'(n << 5));
            wb(1'b1, 3'h1, 8'ha0);
            @(posedge clk);
            trig <= 7'h7f ^ 7'(1 << (n - 1));
            count_samp(60, c);
            chk(32'(c), 32'h0);
            trig <= 7'h7f;
            count_samp(80, c);
            chk(32'(c), 32'h1);
            trig <= 7'h00;
        end
    endtask : s_trig

    task automatic s_done();
        wb(1'b1, 3'h1, 8'h90);
        wb(1'b1, 3'h0, 8'h0d);
        next_code = 10'h270;
        wb(1'b1, 3'h1, 8'hc0);
        wb(1'b1, 3'h1, 8'h80);
        wb(1'b1, 3'h0, 8'h01);
        wb(1'b0, 3'h1, 8'h00);
        chk(32'(q[6]), 32'h1);
        chk(32'(q[4]), 32'h0);
        chk(32'(pos), 32'h3);
        wait_idle();
        chk(32'(q[4]), 32'h1);
        wb(1'b0, 3'h2, 8'h00);
        chk(32'(q), 32'h70);
        wb(1'b0, 3'h3, 8'h00);
        chk(32'(q), 32'h02);
        wb(1'b1, 3'h0, 8'h21);
        wb(1'b0, 3'h2, 8'h00);
        chk(32'(q), 32'h00);
        wb(1'b0, 3'h3, 8'h00);
        chk(32'(q), 32'h9c);
        wb(1'b1, 3'h5, 8'h01);
        wb(1'b1, 3'h1, 8'h88);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1);
        wb(1'b1, 3'h5, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        wb(1'b1, 3'h5, 8'h01);
        wb(1'b1, 3'h1, 8'h98);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        // low read locks the pair, so the new code must not show in the high byte
        wb(1'b0, 3'h2, 8'h00);
        next_code = 10'h1ff;
        wb(1'b1, 3'h1, 8'hc8);
        wait_idle();
        wb(1'b0, 3'h3, 8'h00);
        chk(32'(q), 32'h9c);
        wb(1'b1, 3'h1, 8'hd8);
        wait_idle();
        wb(1'b0, 3'h3, 8'h00);
        chk(32'(q), 32'h7f);
        wb(1'b0, 3'h2, 8'h00);
        chk(32'(q), 32'hc0);
        chk(32'(irq), 32'h1);
        wb(1'b1, 3'h5, 8'h03);
        wb(1'b0, 3'h1, 8'h00);
        chk(32'({q[4], irq}), 32'h0);
    endtask : s_done

    initial begin
        {cyc, stb, we, adr, dat_w, trig, next_code} = '0;
        sel = 4'hf;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        s_regs();
        s_mux();
        s_free();
        s_trig();
        s_done();
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule : testbench

bind adcsq_control adcsq_sva u_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .CONV_SAMPLE_O(CONV_SAMPLE_O),
    .CONV_POWER_O(CONV_POWER_O), .POS_INPUT_O(POS_INPUT_O), .GAIN_O(GAIN_O),
    .DIFFERENTIAL_O(DIFFERENTIAL_O), .BANDGAP_SEL_O(BANDGAP_SEL_O), .GROUND_SEL_O(GROUND_SEL_O));
